/* File: rtl/multi_mode_port.sv */
`timescale 1ns/1ps
`include "mmp_cfg.svh"
// Summary of operation
// - one mode only: gpio, 1284 or host
// - host mode reaches shared ram and fifo
// - mode strapped from address lines at reset
// - 1284 talks to one channel at once
// - one shared data bus to all transceivers
// - active-low output enable per channel
// - control strobe per channel loads control transceiver
// - at most one control strobe active
// - data strobe per channel, one at once
// - no data strobe while control strobe active
// - no control strobe while data strobe active
// - per-channel active-low acknowledge input
// - busy, paper error, select, fault inputs
// - dma cycles ignore address, fifo only
// - active-low done answers chip select
// - host data words are 16 bits
// - transceiver direction and enable outputs
module multi_mode_port
	import mmp_pkg::*;
(
	input	wire logic						clk,
	input	wire logic						reset_n,
	input	wire logic	[`MODE_CODE_W-1:0]	mode_strap,
	input	wire logic	[`CHAN_SEL_W-1:0]	chan_select,
	input	wire logic						ctrl_load,
	input	wire logic						data_load,
	input	wire logic						chan_drive,
	input	wire logic	[`DATA_W-1:0]		load_value,
	output	peripheral_status_s				chan_status,
	output	port_mode_e						port_mode,
	input	wire logic	[`DATA_W-1:0]		port_data_bus_in,
	output	logic	[`DATA_W-1:0]			port_data_bus_out,
	output	logic							port_data_bus_oe_n,
	output	logic	[`CHAN_COUNT-1:0]		channel_output_enable_n,
	output	logic	[`CHAN_COUNT-1:0]		channel_control_strobe,
	output	logic	[`CHAN_COUNT-1:0]		channel_data_strobe,
	input	wire logic	[`CHAN_COUNT-1:0]	peripheral_acknowledge_n,
	input	wire logic	[`CHAN_COUNT-1:0]	peripheral_busy_n,
	input	wire logic	[`CHAN_COUNT-1:0]	paper_error_n,
	input	wire logic	[`CHAN_COUNT-1:0]	peripheral_select_n,
	input	wire logic	[`CHAN_COUNT-1:0]	peripheral_fault_n,
	input	wire logic						host_chip_select_n,
	input	wire logic						host_read_write_n,
	input	wire logic	[`ADDR_W-1:0]		host_address,
	input	wire logic						host_dma_ack_n,
	output	logic							host_cycle_done_n,
	output	logic							transceiver_direction,
	output	logic							transceiver_enable_n
);
	////////////////////////////////////////////////////////////////////////////
	// reset leaves through two flops so no register sees a release mid-cycle
	logic	rst_meta;
	logic	rst_n;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// strap caught once, on the first clocked cycle after release
	// strap_taken keeps a later strap change from flipping the mode mid-run
	logic		strap_taken;
	port_mode_e	next_mode;
	wire		is_1284 = (port_mode == mode_1284);
	wire		is_host = (port_mode == mode_host);
	// limitation: the low two strap bits of a host code are not told apart
	wire		strap_host = mode_strap[`MODE_CODE_W-1];
	assign next_mode = (mode_strap == `MODE_CODE_1284) ? mode_1284 :
		(strap_host ? mode_host : mode_gpio);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			strap_taken <= 1'b0;
			port_mode <= mode_gpio;
		end else if (!strap_taken) begin
			strap_taken <= 1'b1;
			port_mode <= next_mode;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// 1284: one strobe pulse at a time on the selected channel
	typedef enum logic [1:0] {st_idle, st_ctrl, st_data} strobe_e;
	strobe_e			strobe_state;
	logic	[1:0]		strobe_count;
	logic	[`CHAN_SEL_W-1:0]	active_chan;
	logic	[`DATA_W-1:0]	load_latch;
	logic	[`CHAN_COUNT-1:0]	chan_onehot;
	wire				ctrl_go = is_1284 && ctrl_load;
	wire				data_go = is_1284 && data_load;
	wire				strobe_busy = (strobe_state != st_idle);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			strobe_state <= st_idle;
			strobe_count <= 2'h0;
			active_chan <= 2'h0;
			load_latch <= 16'h0000;
		end else begin
			case (strobe_state)
				st_idle: begin
					// control wins when both are asked in one cycle
					if (ctrl_go) begin
						strobe_state <= st_ctrl;
						active_chan <= chan_select;
						load_latch <= load_value;
						strobe_count <= 2'(`STROBE_CYCLES);
					end else if (data_go) begin
						strobe_state <= st_data;
						active_chan <= chan_select;
						load_latch <= load_value;
						strobe_count <= 2'(`STROBE_CYCLES);
					end else
						active_chan <= chan_select;
				end
				default: begin
					if (strobe_count <= 2'h1)
						strobe_state <= st_idle;
					else
						strobe_count <= strobe_count - 2'h1;
				end
			endcase
		end
	end

	genvar ch;
	generate
		for (ch = 0; ch < `CHAN_COUNT; ch++) begin : g_chan
			assign chan_onehot[ch] = (active_chan == 2'(ch));
		end
	endgenerate

	// only ever the single one-hot lane is driven: no two strobes overlap
	assign channel_control_strobe = (strobe_state == st_ctrl) ? chan_onehot :
		4'h0;
	assign channel_data_strobe = (strobe_state == st_data) ? chan_onehot :
		4'h0;
	// enable stays off during a strobe so the shared bus has a single driver
	assign channel_output_enable_n = (is_1284 && chan_drive && !strobe_busy) ?
		~chan_onehot : 4'hf;

	////////////////////////////////////////////////////////////////////////////
	// status of the selected channel; meaning is left to the phase logic
	// one cycle late: the pins pass a flop before anyone reads them
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			chan_status <= '1;
		else if (is_1284) begin
			chan_status.ack_n <= peripheral_acknowledge_n[active_chan];
			chan_status.busy_n <= peripheral_busy_n[active_chan];
			chan_status.paper_error_n <= paper_error_n[active_chan];
			chan_status.select_n <= peripheral_select_n[active_chan];
			chan_status.fault_n <= peripheral_fault_n[active_chan];
		end else
			chan_status <= '1;
	end

	////////////////////////////////////////////////////////////////////////////
	// host: access taken on chip select fall, done held until it rises
	typedef enum logic [1:0] {hs_idle, hs_busy, hs_done} host_e;
	host_e			host_state;
	host_req_s		host_cmd;
	logic			host_dma;
	logic			host_req;
	logic	[`DATA_W-1:0]	host_rdata;
	// the request is captured whole at the first edge, so later wobble is harmless
	wire			host_sel = is_host && !host_chip_select_n;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			host_state <= hs_idle;
			host_cmd <= '0;
			host_dma <= 1'b0;
			host_req <= 1'b0;
		end else begin
			host_req <= 1'b0;
			case (host_state)
				hs_idle: if (host_sel) begin
					host_state <= hs_busy;
					host_req <= 1'b1;
					host_cmd.is_write <= !host_read_write_n;
					host_cmd.addr <= host_address;
					host_cmd.data <= port_data_bus_in;
					host_dma <= !host_dma_ack_n;
				end
				hs_busy: host_state <= hs_done;
				default: if (!host_sel)
					host_state <= hs_idle;
			endcase
		end
	end

	host_store u_store (
		.clk	(clk),
		.rst_n	(rst_n),
		.req	(host_req),
		.cmd	(host_cmd),
		.dma	(host_dma),
		.rdata	(host_rdata)
	);

	wire			host_done = (host_state == hs_done) && host_sel;
	wire			host_reading = host_sel && !host_cmd.is_write && (host_state != hs_idle);

	assign host_cycle_done_n = !host_done;
	// direction turns a cycle before the bus drives, so the buffer never fights the host
	assign transceiver_direction = !host_reading;
	assign transceiver_enable_n = !host_sel;

	////////////////////////////////////////////////////////////////////////////
	// one shared bus; active low enable, released in gpio mode
	wire			bus_drive_1284 = is_1284 && strobe_busy;
	wire			bus_drive_host = is_host && host_done && !host_cmd.is_write;
	assign port_data_bus_out = is_host ? host_rdata : load_latch;
	assign port_data_bus_oe_n = !(bus_drive_1284 || bus_drive_host);
endmodule : multi_mode_port

/* File: rtl/mmp_cfg.svh */
`ifndef MMP_CFG_SVH
`define MMP_CFG_SVH
// mode straps, sampled from three upper address lines at reset release
`define MODE_CODE_W        3
`define MODE_CODE_GPIO     3'h0
`define MODE_CODE_1284     3'h1
`define MODE_CODE_SHARED16 3'h4
`define MODE_CODE_FIFO     3'h5
`define CHAN_COUNT         4
`define CHAN_SEL_W         2
`define DATA_W             16
`define ADDR_W             17
`define RAM_WORDS          256
`define RAM_INDEX_W        8
`define FIFO_DEPTH         16
`define FIFO_PTR_W         4
`define FIFO_DATA_ADDR     17'h1fffe
`define FIFO_STAT_ADDR     17'h1fffc
// strobe high time in clk cycles: one 20 ns cycle at 50 MHz
`define STROBE_NS          20
`define CLK_MHZ            50
`define STROBE_CYCLES      ((`STROBE_NS * `CLK_MHZ + 999) / 1000)
`endif

/* File: rtl/mmp_pkg.sv */
`include "mmp_cfg.svh"
package mmp_pkg;
	typedef enum logic [1:0] {mode_gpio, mode_1284, mode_host} port_mode_e;
	typedef struct packed {
		logic	busy_n;
		logic	paper_error_n;
		logic	select_n;
		logic	fault_n;
		logic	ack_n;
	} peripheral_status_s;
	typedef struct packed {
		logic				is_write;
		logic	[`ADDR_W-1:0]	addr;
		logic	[`DATA_W-1:0]	data;
	} host_req_s;
endpackage : mmp_pkg

/* File: rtl/host_store.sv */
`timescale 1ns/1ps
`include "mmp_cfg.svh"
module host_store
	import mmp_pkg::*;
(
	input	wire logic			clk,
	input	wire logic			rst_n,
	input	wire logic			req,
	input	wire host_req_s		cmd,
	input	wire logic			dma,
	output	logic	[`DATA_W-1:0]	rdata
);
	// shared ram plus one fifo reachable through a single data address or any dma cycle
	logic	[`DATA_W-1:0]		ram [`RAM_WORDS];
	logic	[`DATA_W-1:0]		fifo [`FIFO_DEPTH];
	logic	[`FIFO_PTR_W-1:0]	wp;
	logic	[`FIFO_PTR_W-1:0]	rp;
	logic	[`FIFO_PTR_W:0]		cnt;
	wire						to_fifo = dma || (cmd.addr == `FIFO_DATA_ADDR);
	wire						to_stat = !dma && (cmd.addr == `FIFO_STAT_ADDR);
	wire						push = req && cmd.is_write && to_fifo && (cnt != 5'(`FIFO_DEPTH));
	wire						pop = req && !cmd.is_write && to_fifo && (cnt != 5'h00);
	wire	[`RAM_INDEX_W-1:0]	idx = cmd.addr[`RAM_INDEX_W-1:0];
	always_ff @(posedge clk) begin
		if (req && cmd.is_write && !to_fifo && !to_stat)
			ram[idx] <= cmd.data;
		if (push)
			fifo[wp] <= cmd.data;
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp <= 4'h0;
			rp <= 4'h0;
			cnt <= 5'h00;
			rdata <= 16'h0000;
		end else begin
			if (push)
				wp <= wp + 4'h1;
			if (pop)
				rp <= rp + 4'h1;
			cnt <= cnt + {4'h0, push} - {4'h0, pop};
			if (req && !cmd.is_write) begin
				if (to_fifo)
					rdata <= pop ? fifo[rp] : 16'h0000;
				else if (to_stat)
					rdata <= {11'h000, cnt};
				else
					rdata <= ram[idx];
			end
		end
	end
endmodule : host_store

/* File: test/periph_model.sv */
`timescale 1ns/1ps
module periph_model (
	input	wire logic			clk,
	input	wire logic	[19:0]	pattern,
	output	logic		[19:0]	pins
);
	// pins move only on clk, so the port never sees a change mid-cycle
	always_ff @(posedge clk) begin
		pins <= pattern;
	end
endmodule : periph_model

/* File: test/mmp_properties.sv */
`timescale 1ns/1ps
`include "mmp_cfg.svh"
module mmp_properties
	import mmp_pkg::*;
(
	input	wire logic						clk,
	input	wire logic						reset_n,
	input	wire logic	[`CHAN_SEL_W-1:0]	chan_select,
	input	wire logic						ctrl_load,
	input	wire logic						data_load,
	input	wire port_mode_e				port_mode,
	input	wire logic						port_data_bus_oe_n,
	input	wire logic	[`CHAN_COUNT-1:0]	channel_output_enable_n,
	input	wire logic	[`CHAN_COUNT-1:0]	channel_control_strobe,
	input	wire logic	[`CHAN_COUNT-1:0]	channel_data_strobe,
	input	wire logic						host_chip_select_n,
	input	wire logic						host_read_write_n,
	input	wire logic						host_cycle_done_n,
	input	wire logic						transceiver_direction
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	wire	any_c = |channel_control_strobe;
	wire	any_d = |channel_data_strobe;
	wire	host_rd = !host_cycle_done_n && host_read_write_n && !host_chip_select_n;
	sequence idle_load_s;
		port_mode == mode_1284 && (ctrl_load || data_load) && !any_c && !any_d;
	endsequence
	sequence pulse_s;
		(any_c || any_d) ##1 !(any_c || any_d);
	endsequence
	sequence host_start_s;
		port_mode == mode_host && $fell(host_chip_select_n);
	endsequence
	sequence done_wait_s;
		host_cycle_done_n [*2] ##1 !host_cycle_done_n;
	endsequence
	one_ctrl_a: assert property ($onehot0(channel_control_strobe))
		else $error("two control strobes high");
	one_data_a: assert property ($onehot0(channel_data_strobe))
		else $error("two data strobes high");
	strobe_excl_a: assert property (!(any_c && any_d))
		else $error("data and control strobes together");
	one_enable_a: assert property ($onehot0(~channel_output_enable_n))
		else $error("two output enables low");
	mode_idle_a: assert property (port_mode != mode_1284 |->
		!any_c && !any_d && &channel_output_enable_n) else $error("channel active outside 1284");
	load_pulse_a: assert property (idle_load_s |=> pulse_s)
		else $error("strobe not a single pulse");
	strobe_chan_a: assert property (idle_load_s |=>
		($past(ctrl_load) ? channel_control_strobe : channel_data_strobe) ==
		(4'h1 << $past(chan_select))) else $error("wrong strobe");
	done_delay_a: assert property (host_start_s |-> done_wait_s)
		else $error("done not at 2");
	done_release_a: assert property ($rose(host_chip_select_n) |->
		##[0:1] host_cycle_done_n) else $error("done held after deselect");
	read_drive_a: assert property (host_rd |->
		!port_data_bus_oe_n && !transceiver_direction) else $error("read not driven");
endmodule : mmp_properties

/* File: test/multi_mode_parallel_host_port_test.sv */
`timescale 1ns/1ps
`include "mmp_cfg.svh"
module multi_mode_parallel_host_port_test;
	import mmp_pkg::*;
	logic			clk = 0, reset_n = 0, ctrl_load = 0, data_load = 0, chan_drive = 0;
	logic			cs_n = 1, rw_n = 1, dma_n = 1, bus_oe_n, done_n, tdir, ten_n;
	logic	[2:0]	strap = 3'h0;
	logic	[1:0]	sel = 2'h0;
	logic	[15:0]	lv = 16'h0, din = 16'h0, dout, rd;
	logic	[16:0]	addr = 17'h0;
	logic	[19:0]	pat = 20'h0, pins;
	logic	[4:0]	exp_st;
	logic	[3:0]	poe_n, cstb, dstb;
	peripheral_status_s	st;
	port_mode_e		pm;
	int				errors = 0, num_checks = 0, cycles = 0, seed = 5840, i, k;
	int				ram [256];
	int				fq [$];
	multi_mode_port dut_u (.clk(clk), .reset_n(reset_n), .mode_strap(strap), .chan_select(sel),
		.ctrl_load(ctrl_load), .data_load(data_load), .chan_drive(chan_drive), .load_value(lv),
		.chan_status(st), .port_mode(pm), .port_data_bus_in(din), .port_data_bus_out(dout),
		.port_data_bus_oe_n(bus_oe_n), .channel_output_enable_n(poe_n),
		.channel_control_strobe(cstb), .channel_data_strobe(dstb),
		.peripheral_busy_n(pins[19:16]), .paper_error_n(pins[15:12]),
		.peripheral_select_n(pins[11:8]), .peripheral_fault_n(pins[7:4]),
		.peripheral_acknowledge_n(pins[3:0]), .host_chip_select_n(cs_n),
		.host_read_write_n(rw_n), .host_address(addr), .host_dma_ack_n(dma_n),
		.host_cycle_done_n(done_n), .transceiver_direction(tdir), .transceiver_enable_n(ten_n));
	periph_model peer_u (.clk(clk), .pattern(pat), .pins(pins));
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles > 5000) begin
			errors++;
			complete_run;
		end
	end
	task automatic tick;
		@(posedge clk);
		#2;
	endtask : tick
	task automatic chk(string n, logic [31:0] s, logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			errors++;
			$display("CHECK FAILED %s exp %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic do_reset(logic [2:0] s);
		reset_n = 0;
		strap = s;
		repeat (5) tick;
		reset_n = 1;
		repeat (4) tick;
	endtask : do_reset
	// request held through the edge that samples done low, then one idle cycle
	task automatic host(logic w, logic d, logic [16:0] a, logic [15:0] v);
		int n;
		cs_n = 0;
		rw_n = !w;
		dma_n = !d;
		addr = a;
		din = v;
		for (n = 0; n < 8 && done_n !== 1'b0; n++) tick;
		chk("done_n", done_n, 1'b0);
		chk("done_lat", n, 2);
		chk("xcvr", {ten_n, tdir, bus_oe_n}, {1'b0, w, w});
		rd = dout;
		tick;
		chk("done_hold", done_n, 1'b0);
		cs_n = 1;
		tick;
		chk("xcvr_off", {ten_n, tdir, done_n}, 3'h7);
	endtask : host
	task automatic complete_run;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : complete_run
	initial begin
		for (i = 0; i < 8; i++) begin
			do_reset(3'(i));
			chk("mode", pm, i == 1 ? mode_1284 : i >= 4 ? mode_host : mode_gpio);
			ctrl_load = 1;
			tick;
			ctrl_load = 0;
			chk("cstb", cstb, i == 1 ? 4'h1 << sel : 4'h0);
			chk("oe", bus_oe_n, i != 1);
		end
		$display("test straps done");
		do_reset(3'h1);
		for (i = 0; i < 12; i++) begin
			sel = 2'(i % 4);
			k = i / 4;
			lv = 16'($random(seed));
			pat = 20'($random(seed));
			ctrl_load = k != 1;
			data_load = k != 0;
			tick;
			chk("cstb", cstb, k != 1 ? 4'h1 << sel : 4'h0);
			chk("dstb", dstb, k == 1 ? 4'h1 << sel : 4'h0);
			chk("bus", {bus_oe_n, dout}, {1'b0, lv});
			// a load held during the pulse is dropped, so the next cycle is quiet
			tick;
			ctrl_load = 0;
			data_load = 0;
			chk("gap", {cstb, dstb}, 8'h00);
			chan_drive = 1;
			repeat (5) tick;
			chk("poe_n", poe_n, 4'(~(4'h1 << sel)));
			exp_st = {pat[16+sel], pat[12+sel], pat[8+sel], pat[4+sel], pat[sel]};
			chk("status", st, exp_st);
			chan_drive = 0;
		end
		$display("test 1284 done");
		do_reset(3'h4);
		for (i = 0; i < 4; i++) begin
			lv = 16'($random(seed));
			ram[i * 61] = lv;
			host(1, 0, 17'(i * 61), lv);
		end
		for (i = 0; i < 4; i++) begin
			host(0, 0, 17'(i * 61), 16'h0);
			chk("ram", rd, ram[i * 61]);
		end
		for (i = 0; i < 3; i++) begin
			lv = 16'($random(seed));
			fq.push_back(lv);
			host(1, i == 1, i == 1 ? 17'($random(seed)) : `FIFO_DATA_ADDR, lv);
		end
		host(0, 0, `FIFO_STAT_ADDR, 16'h0);
		chk("count", rd, 3);
		for (i = 0; i < 4; i++) begin
			host(0, i == 2, i == 2 ? 17'h00000 : `FIFO_DATA_ADDR, 16'h0);
			chk("fifo", rd, fq.size() > 0 ? fq.pop_front() : 0);
		end
		$display("test host done");
		complete_run;
	end
endmodule : multi_mode_parallel_host_port_test
bind multi_mode_port mmp_properties chk_u (.clk(clk), .reset_n(reset_n),
	.chan_select(chan_select), .ctrl_load(ctrl_load), .data_load(data_load),
	.port_mode(port_mode), .port_data_bus_oe_n(port_data_bus_oe_n),
	.channel_output_enable_n(channel_output_enable_n),
	.channel_control_strobe(channel_control_strobe), .channel_data_strobe(channel_data_strobe),
	.host_chip_select_n(host_chip_select_n), .host_read_write_n(host_read_write_n),
	.host_cycle_done_n(host_cycle_done_n), .transceiver_direction(transceiver_direction));
